/* File: dv/sdif_ctrl_model.sv */
// Behavioural motion controller driving the digital input pins
`timescale 1ns/1ps
module sdif_ctrl_model (
    input wire logic mclk,           // Drive clock
    input wire logic zero_speed_out, // Drive at zero speed
    output sdif_pkg::sdif_di_s di    // Digital input pins
);
    initial di = '0;

    // Hold new levels long enough for the input filter
    task automatic set_levels(input sdif_pkg::sdif_di_s v);
        @(posedge mclk);
        di <= v;
        repeat (6) @(posedge mclk);
    endtask

    // Raise the masked pins, hold, then drop them again
    task automatic pulse(input sdif_pkg::sdif_di_s m);
        int n;
        n = 0;
        while (m.position_trigger && zero_speed_out !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        di <= di | m;
        repeat (6) @(posedge mclk);
        di <= di & ~m;
        repeat (6) @(posedge mclk);
    endtask
endmodule // sdif_ctrl_model

/* File: dv/sdif_top_properties.sv */
// Concurrent checks on the ports of the digital input decoder
`timescale 1ns/1ps
module sdif_top_properties #(
    parameter int SPEED_W = 16
) (
    input wire logic mclk,                  // Clock
    input wire logic srst,                  // Reset
    input wire logic [SPEED_W-1:0] motor_speed, // Speed
    input wire logic fault_clear,           // Clear faults
    input wire logic deviation_clear,       // Clear deviation
    input wire logic feedback_clear,        // Clear feedback
    input wire logic motion_abort,          // Abort
    input wire logic move_start,            // New move
    input wire logic zero_clamp_lock,       // Hold position
    input wire logic torque_limit_valid,    // Torque limit
    input wire logic speed_limit_valid,     // Speed limit
    input wire logic target_reached_out,    // Target reached
    input wire logic zero_speed_out         // Zero speed
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_fault_pulse;
        fault_clear |=> !fault_clear;
    endproperty
    a_fault_pulse: assert property (p_fault_pulse)
        else $error("fault clear longer than one cycle");
    property p_move_pulse;
        move_start |=> !move_start;
    endproperty
    a_move_pulse: assert property (p_move_pulse)
        else $error("move start longer than one cycle");
    property p_move_at_zero;
        move_start |-> $past(zero_speed_out);
    endproperty
    a_move_at_zero: assert property (p_move_at_zero)
        else $error("move started while not at zero speed");
    property p_clear_one;
        deviation_clear |-> !feedback_clear && !motion_abort;
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("two clear actions at once");
    property p_abort_unreached;
        motion_abort |-> !target_reached_out;
    endproperty
    a_abort_unreached: assert property (p_abort_unreached)
        else $error("target reached during abort");
    property p_reached_stop;
        $rose(target_reached_out) |-> zero_speed_out;
    endproperty
    a_reached_stop: assert property (p_reached_stop)
        else $error("target reached while moving");
    property p_zero_fast;
        $past(motor_speed) == '1 |-> !zero_speed_out;
    endproperty
    a_zero_fast: assert property (p_zero_fast)
        else $error("zero speed flagged at full speed");
    property p_clamp_fast;
        $past(motor_speed) == '1 && motor_speed == '1 |-> !zero_clamp_lock;
    endproperty
    a_clamp_fast: assert property (p_clamp_fast)
        else $error("clamp held at full speed");
    property p_limits;
        torque_limit_valid |-> !speed_limit_valid;
    endproperty
    a_limits: assert property (p_limits)
        else $error("torque and speed limit both valid");

    c_move: cover property (move_start);
    c_abort: cover property (motion_abort);
    c_fb: cover property (feedback_clear);
endmodule // sdif_top_properties

bind sdif_top sdif_top_properties #(.SPEED_W(SPEED_W)) u_props (.mclk,
    .srst, .motor_speed, .fault_clear, .deviation_clear, .feedback_clear,
    .motion_abort, .move_start, .zero_clamp_lock, .torque_limit_valid,
    .speed_limit_valid, .target_reached_out, .zero_speed_out);

/* File: dv/tb.sv */
// Self-checking testbench for the digital input decoder
`timescale 1ns/1ps
module tb;
    logic mclk = 0;
    logic srst = 1;
    logic psel = 0, penable = 0, pwrite = 0, clr_seen = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, move_target, got_tgt = '0;
    logic pready, pslverr, er;
    logic [15:0] motor_speed = '0;
    logic servo_ready, fault_clear, gain_boost, deviation_clear;
    logic feedback_clear, motion_abort, zero_clamp_lock, direction_invert;
    logic motion_pause, move_start, torque_limit_valid, speed_limit_valid;
    logic target_reached_out, zero_speed_out;
    logic [4:0] seen = '0;
    sdif_pkg::sdif_di_s di;
    int err_count = 0, tests_run = 0, cycles = 0;
    logic [7:0] cl_ctrl [6] = '{8'h01, 8'h05, 8'h09, 8'h08, 8'h02, 8'h0d};
    logic [4:0] cl_exp [6] = '{5'h18, 5'h14, 5'h12, 5'h10, 5'h10, 5'h12};
    logic [6:0] lv_exp [4] = '{7'h65, 7'h7d, 7'h75, 7'h53};

    always #10 mclk = ~mclk;

    sdif_ctrl_model ctl (.mclk, .zero_speed_out, .di);
    sdif_top dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .servo_enable_in(di.servo_enable),
        .fault_clear_in(di.fault_clear), .gain_boost_in(di.gain_boost),
        .pulse_clear_in(di.pulse_clear), .zero_clamp_in(di.zero_clamp),
        .command_invert_in(di.command_invert),
        .position_pause_in(di.position_pause),
        .position_trigger_in(di.position_trigger),
        .torque_limit_en_in(di.torque_limit_en),
        .speed_limit_en_in(di.speed_limit_en),
        .position_select_bit0(di.position_select[0]),
        .position_select_bit1(di.position_select[1]),
        .position_select_bit2(di.position_select[2]), .motor_speed,
        .servo_ready, .fault_clear, .gain_boost, .deviation_clear,
        .feedback_clear, .motion_abort, .zero_clamp_lock, .direction_invert,
        .motion_pause, .move_start, .move_target, .torque_limit_valid,
        .speed_limit_valid, .target_reached_out, .zero_speed_out);

    // Pulse collector and hang guard
    always @(posedge mclk) begin
        seen <= clr_seen ? '0 : seen | {fault_clear, deviation_clear,
            feedback_clear, motion_abort, move_start};
        if (move_start) got_tgt <= move_target;
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask

    task clear_seen;
        clr_seen <= 1;
        @(posedge mclk);
        clr_seen <= 0;
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        srst <= 0;
        @(posedge mclk);
        apb(0, sdif_pkg::ADDR_ZERO_THR, '0);
        chk(rd, 32'h0000_000a);
        apb(0, 8'h10, '0);
        chk({rd[30:0], er}, 32'h0000_0001);
        $display("test registers done");
        for (int n = 0; n < 8; n++)
            apb(1, sdif_pkg::ADDR_POS_BASE + 8'(4 * n), 32'h0000_1000 + n);
        apb(1, sdif_pkg::ADDR_CTRL, 32'h0000_0001);
        for (int n = 0; n < 8; n++) begin
            ctl.set_levels(sdif_pkg::sdif_di_s'(13'(n) << 10));
            clear_seen();
            ctl.pulse(sdif_pkg::sdif_di_s'(13'h0080));
            chk(seen, 32'h0000_0001);
            chk(got_tgt, 32'h0000_1000 + n);
        end
        apb(1, sdif_pkg::ADDR_CTRL, 32'h0000_0002);
        clear_seen();
        ctl.pulse(sdif_pkg::sdif_di_s'(13'h0080));
        chk(seen, '0);
        // Trigger while the motor still turns must be refused
        apb(1, sdif_pkg::ADDR_CTRL, 32'h0000_0001);
        motor_speed <= '1;
        clear_seen();
        ctl.pulse(sdif_pkg::sdif_di_s'(13'h0080));
        chk(seen, '0);
        motor_speed <= '0;
        $display("test triggers done");
        for (int i = 0; i < 6; i++) begin
            apb(1, sdif_pkg::ADDR_CTRL, 32'(cl_ctrl[i]));
            clear_seen();
            ctl.pulse(sdif_pkg::sdif_di_s'(13'h000a));
            chk(seen, 32'(cl_exp[i]));
        end
        chk(target_reached_out, 1);
        // Mode 3 with a turning motor: target only after it stops
        motor_speed <= '1;
        ctl.pulse(sdif_pkg::sdif_di_s'(13'h0008));
        chk(target_reached_out, 0);
        motor_speed <= '0;
        repeat (3) @(posedge mclk);
        chk(target_reached_out, 1);
        $display("test clear modes done");
        ctl.set_levels(sdif_pkg::sdif_di_s'(13'h0375));
        for (int m = 0; m < 4; m++) begin
            apb(1, sdif_pkg::ADDR_CTRL, 32'h0000_0030 + m);
            repeat (8) @(posedge mclk);
            chk({servo_ready, gain_boost, direction_invert, motion_pause,
                torque_limit_valid, speed_limit_valid, zero_clamp_lock},
                32'(lv_exp[m]));
        end
        motor_speed <= '1;
        repeat (4) @(posedge mclk);
        chk({zero_clamp_lock, zero_speed_out}, '0);
        apb(1, sdif_pkg::ADDR_CTRL, 32'h0000_0010);
        repeat (4) @(posedge mclk);
        chk(servo_ready, '0);
        $display("test levels done");
        tally_and_finish();
    end
endmodule // tb

/* File: rtl/sdif_pkg.sv */
// Shared constants and types for the servo digital input decoder
package sdif_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ZERO_THR = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_POS_BASE = 8'h20;
    localparam logic [7:0] ADDR_POS_LAST = 8'h3c;
    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CLRM_LSB = 2;
    localparam int CTRL_GSW_BIT = 4;
    localparam int CTRL_SEN_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [15:0] ZERO_THR_RESET = 16'h000a;
    // ----------------------------------------
    // Control modes and clear modes
    // ----------------------------------------
    localparam logic [1:0] MODE_TRAIN = 2'h0;
    localparam logic [1:0] MODE_INT = 2'h1;
    localparam logic [1:0] MODE_SPD = 2'h2;
    localparam logic [1:0] MODE_TRQ = 2'h3;
    localparam logic [1:0] CLR_DEV = 2'h0;
    localparam logic [1:0] CLR_FB = 2'h1;
    localparam logic [1:0] CLR_ABORT = 2'h2;
    localparam logic [1:0] CLR_ABORT_DONE = 2'h3;
    // ----------------------------------------
    // Digital input bundle
    // ----------------------------------------
    localparam int DI_W = 13;
    typedef struct packed {
        logic [2:0] position_select;   // bit2..bit0
        logic speed_limit_en;
        logic torque_limit_en;
        logic position_trigger;
        logic position_pause;
        logic command_invert;
        logic zero_clamp;
        logic pulse_clear;
        logic gain_boost;
        logic fault_clear;
        logic servo_enable;
    } sdif_di_s;
endpackage

/* File: rtl/sdif_top.sv */
// Servo digital input function decoder with APB configuration
// Contract
// - Servo enable input makes servo ready
// - Fault clear input clears clearable faults
// - Gain boost in speed/position when configured
// - Pulse clear runs selected clear mode
// - Mode 0 clears deviation, position modes only
// - Mode 1 clears feedback and turns, position modes only
// - Mode 2 aborts motion, internal position only
// - Mode 3 aborts, target after stop, internal position only
// - Zero clamp locks motor below threshold
// - Invert reverses in internal position, speed, torque
// - Pause halts motion in internal position mode
// - Trigger moves to selected stored position
// - Trigger acts on rising edge only
// - Retrigger accepted only at zero speed
// - Torque limit valid in speed/position
// - Speed limit valid in torque mode
// - Three select bits pick eight positions
`timescale 1ns/1ps
module sdif_top #(
    parameter int SPEED_W = 16,
    parameter int POS_W = 32
) (
    input wire logic mclk,                  // 50 MHz clock
    input wire logic srst,                  // Sync reset, high
    input wire logic psel,                  // APB select
    input wire logic penable,               // APB enable
    input wire logic pwrite,                // APB direction
    input wire logic [7:0] paddr,           // APB byte address
    input wire logic [31:0] pwdata,         // APB write data
    output logic [31:0] prdata,             // APB read data
    output logic pready,                    // APB ready
    output logic pslverr,                   // APB error
    input wire logic servo_enable_in,       // Servo on pin
    input wire logic fault_clear_in,        // Fault clear pin
    input wire logic gain_boost_in,         // Gain boost pin
    input wire logic pulse_clear_in,        // Pulse clear pin
    input wire logic zero_clamp_in,         // Zero clamp pin
    input wire logic command_invert_in,     // Command invert pin
    input wire logic position_pause_in,     // Position pause pin
    input wire logic position_trigger_in,   // Position trigger pin
    input wire logic torque_limit_en_in,    // Torque limit pin
    input wire logic speed_limit_en_in,     // Speed limit pin
    input wire logic position_select_bit0,  // Position select 0
    input wire logic position_select_bit1,  // Position select 1
    input wire logic position_select_bit2,  // Position select 2
    input wire logic [SPEED_W-1:0] motor_speed, // Speed magnitude
    output logic servo_ready,               // Servo ready level
    output logic fault_clear,               // Clear faults pulse
    output logic gain_boost,                // Boosted gain level
    output logic deviation_clear,           // Clear deviation pulse
    output logic feedback_clear,            // Clear feedback pulse
    output logic motion_abort,              // Abort motion pulse
    output logic zero_clamp_lock,           // Hold position level
    output logic direction_invert,          // Reverse level
    output logic motion_pause,              // Pause level
    output logic move_start,                // New move pulse
    output logic [POS_W-1:0] move_target,   // Move position
    output logic torque_limit_valid,        // Torque limit level
    output logic speed_limit_valid,         // Speed limit level
    output logic target_reached_out,        // Target reached
    output logic zero_speed_out             // Speed below threshold
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    sdif_pkg::sdif_di_s pin_raw;
    logic [sdif_pkg::DI_W-1:0] sync1, sync2, sync3;
    logic [sdif_pkg::DI_W-1:0] filt, next_filt, filt_d;
    sdif_pkg::sdif_di_s di, di_d;

    assign pin_raw = '{
        position_select: {position_select_bit2, position_select_bit1,
                          position_select_bit0},
        speed_limit_en: speed_limit_en_in,
        torque_limit_en: torque_limit_en_in,
        position_trigger: position_trigger_in,
        position_pause: position_pause_in,
        command_invert: command_invert_in,
        zero_clamp: zero_clamp_in,
        pulse_clear: pulse_clear_in,
        gain_boost: gain_boost_in,
        fault_clear: fault_clear_in,
        servo_enable: servo_enable_in};

    genvar gi;
    generate
        for (gi = 0; gi < sdif_pkg::DI_W; gi++) begin : g_sync
            always_comb begin
                next_filt[gi] = filt[gi];
                if (sync2[gi] == sync3[gi]) begin
                    next_filt[gi] = sync3[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            filt <= '0;
            filt_d <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= next_filt;
            filt_d <= filt;
        end
    end

    assign di = filt;
    assign di_d = filt_d;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [5:0] ctrl, next_ctrl;
    logic [15:0] zero_thr, next_zero_thr;
    logic [POS_W-1:0] pos_mem [8];
    logic [1:0] mode, clr_mode;
    logic wr_en, addr_ok, is_pos;
    logic [2:0] pos_idx;

    assign mode = ctrl[sdif_pkg::CTRL_MODE_LSB +: 2];
    assign clr_mode = ctrl[sdif_pkg::CTRL_CLRM_LSB +: 2];
    assign is_pos = paddr >= sdif_pkg::ADDR_POS_BASE &&
                    paddr <= sdif_pkg::ADDR_POS_LAST && paddr[1:0] == 2'h0;
    assign pos_idx = paddr[4:2];
    assign addr_ok = is_pos || paddr == sdif_pkg::ADDR_CTRL ||
                     paddr == sdif_pkg::ADDR_ZERO_THR ||
                     paddr == sdif_pkg::ADDR_STAT;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        next_ctrl = ctrl;
        next_zero_thr = zero_thr;
        if (wr_en && paddr == sdif_pkg::ADDR_CTRL) begin
            next_ctrl = pwdata[5:0];
        end
        if (wr_en && paddr == sdif_pkg::ADDR_ZERO_THR) begin
            next_zero_thr = pwdata[15:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl <= sdif_pkg::CTRL_RESET;
            zero_thr <= sdif_pkg::ZERO_THR_RESET;
        end else begin
            ctrl <= next_ctrl;
            zero_thr <= next_zero_thr;
        end
    end

    // Position table, cleared at reset
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 8; i++) begin
            if (srst) begin
                pos_mem[i] <= '0;
            end else if (wr_en && is_pos && pos_idx == 3'(i)) begin
                pos_mem[i] <= pwdata[POS_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [31:0] stat_word;
    assign stat_word = {3'h0, di, 6'h00, target_reached_out,
                        zero_speed_out, zero_clamp_lock, motion_pause,
                        direction_invert, gain_boost, servo_ready, 3'h0};

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            if (paddr == sdif_pkg::ADDR_CTRL) begin
                prdata = {26'h000_0000, ctrl};
            end else if (paddr == sdif_pkg::ADDR_ZERO_THR) begin
                prdata = {16'h0000, zero_thr};
            end else if (paddr == sdif_pkg::ADDR_STAT) begin
                prdata = stat_word;
            end else if (is_pos) begin
                prdata = 32'(pos_mem[pos_idx]);
            end
        end
    end

    // ----------------------------------------
    // Motion sequencer
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HALT = 3'b010,
        ST_DONE = 3'b100
    } sdif_state_e;
    sdif_state_e state, next_state;

    logic pos_modes, int_mode, at_zero;
    logic trig_rise, clr_rise, fclr_rise;
    logic next_fault_clear, next_dev_clear, next_fb_clear, next_abort;
    logic next_move_start, next_reached;
    logic [POS_W-1:0] next_move_target;

    assign int_mode = mode == sdif_pkg::MODE_INT;
    assign pos_modes = int_mode || mode == sdif_pkg::MODE_TRAIN;
    assign at_zero = motor_speed < SPEED_W'(zero_thr);
    assign trig_rise = di.position_trigger &&
                       !di_d.position_trigger;
    assign clr_rise = di.pulse_clear && !di_d.pulse_clear;
    assign fclr_rise = di.fault_clear && !di_d.fault_clear;

    always_comb begin
        next_state = state;
        next_fault_clear = fclr_rise;
        next_dev_clear = 1'b0;
        next_fb_clear = 1'b0;
        next_abort = 1'b0;
        next_move_start = 1'b0;
        next_move_target = move_target;
        next_reached = target_reached_out;
        if (clr_rise) begin
            unique case (clr_mode)
                sdif_pkg::CLR_DEV: next_dev_clear = pos_modes;
                sdif_pkg::CLR_FB: next_fb_clear = pos_modes;
                sdif_pkg::CLR_ABORT: begin
                    next_abort = int_mode;
                    // Motion cut short, so the target is not reached
                    if (int_mode) begin
                        next_state = ST_IDLE;
                        next_reached = 1'b0;
                    end
                end
                sdif_pkg::CLR_ABORT_DONE: begin
                    next_abort = int_mode;
                    if (int_mode) begin
                        next_state = ST_HALT;
                        next_reached = 1'b0;
                    end
                end
            endcase
        end
        unique case (state)
            ST_IDLE: ;
            ST_HALT: begin
                if (at_zero && !next_abort) begin
                    next_state = ST_DONE;
                    next_reached = 1'b1;
                end
            end
            ST_DONE: ;
        endcase
        // Trigger only in internal position, once speed has settled
        if (trig_rise && int_mode && zero_speed_out &&
            state != ST_HALT && !next_abort) begin
            next_move_start = 1'b1;
            next_move_target = pos_mem[di.position_select];
            next_state = ST_IDLE;
            next_reached = 1'b0;
        end
        if (!int_mode) begin
            next_state = ST_IDLE;
            next_reached = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ST_IDLE;
            fault_clear <= 1'b0;
            deviation_clear <= 1'b0;
            feedback_clear <= 1'b0;
            motion_abort <= 1'b0;
            move_start <= 1'b0;
            move_target <= '0;
            target_reached_out <= 1'b0;
        end else begin
            state <= next_state;
            fault_clear <= next_fault_clear;
            deviation_clear <= next_dev_clear;
            feedback_clear <= next_fb_clear;
            motion_abort <= next_abort;
            move_start <= next_move_start;
            move_target <= next_move_target;
            target_reached_out <= next_reached;
        end
    end

    // ----------------------------------------
    // Level functions
    // ----------------------------------------
    logic next_ready, next_gain, next_lock, next_inv, next_pause;
    logic next_tlim, next_slim;

    always_comb begin
        next_ready = di.servo_enable &&
                     ctrl[sdif_pkg::CTRL_SEN_BIT];
        next_gain = di.gain_boost && ctrl[sdif_pkg::CTRL_GSW_BIT] &&
                    mode != sdif_pkg::MODE_TRQ;
        next_lock = di.zero_clamp && at_zero;
        next_inv = di.command_invert &&
                   mode != sdif_pkg::MODE_TRAIN;
        next_pause = di.position_pause && int_mode;
        next_tlim = di.torque_limit_en &&
                    mode != sdif_pkg::MODE_TRQ;
        next_slim = di.speed_limit_en &&
                    mode == sdif_pkg::MODE_TRQ;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            servo_ready <= 1'b0;
            gain_boost <= 1'b0;
            zero_clamp_lock <= 1'b0;
            direction_invert <= 1'b0;
            motion_pause <= 1'b0;
            torque_limit_valid <= 1'b0;
            speed_limit_valid <= 1'b0;
            zero_speed_out <= 1'b0;
        end else begin
            servo_ready <= next_ready;
            gain_boost <= next_gain;
            zero_clamp_lock <= next_lock;
            direction_invert <= next_inv;
            motion_pause <= next_pause;
            torque_limit_valid <= next_tlim;
            speed_limit_valid <= next_slim;
            zero_speed_out <= at_zero;
        end
    end
endmodule // sdif_top
